// ===== rtl/vcr_defines.svh
// Purpose: register indexes, reset values, masks and trigger codes
//          for the video converter output and calibration register bank
// Assumes: 8-bit register index and 8-bit data on the configuration port
// Notes: reserved bits of masked registers read as zero; coarse gain registers keep their upper bits
`ifndef VCR_DEFINES_SVH
`define VCR_DEFINES_SVH

// register indexes
`define VCR_IDX_OUTPUT_SELECT 8'h2c
`define VCR_IDX_AUX_PLL_RESET 8'h2d
`define VCR_IDX_CONVERTER_CTRL 8'h30
`define VCR_IDX_RED_COARSE 8'h31
`define VCR_IDX_GREEN_COARSE 8'h32
`define VCR_IDX_BLUE_COARSE 8'h33
`define VCR_IDX_RED_FINE 8'h34
`define VCR_IDX_GREEN_FINE 8'h35
`define VCR_IDX_BLUE_FINE 8'h36
`define VCR_IDX_RETURN_CLOCK 8'h37
`define VCR_IDX_RED_COMP 8'h38
`define VCR_IDX_GREEN_COMP 8'h39
`define VCR_IDX_BLUE_COMP 8'h3a
`define VCR_IDX_CAL_ONE 8'h3b
`define VCR_IDX_CAL_TWO 8'h3c

// reset values
`define VCR_RST_OUTPUT_SELECT 8'h41
`define VCR_RST_CONVERTER_CTRL 8'h20
`define VCR_RST_COARSE 8'h20
`define VCR_RST_FINE 8'h20
`define VCR_RST_RETURN_CLOCK 8'hc0
`define VCR_RST_COMP 8'h77
`define VCR_RST_CAL_ONE 8'h2d
`define VCR_RST_CAL_TWO 8'ha5

// writable bit masks, reserved bits held at zero
`define VCR_MASK_OUTPUT_SELECT 8'hf7
`define VCR_MASK_RETURN_CLOCK 8'hef
`define VCR_MASK_CAL_ONE 8'h7f
`define VCR_MASK_FULL 8'hff

// PLL reset trigger nibbles
`define VCR_MCLK_TRIGGER 4'h5
`define VCR_PANEL_TRIGGER 4'ha

// field positions
`define VCR_OSEL_HIGH_DRIVE 7
`define VCR_OSEL_OSC_ENABLE 6
`define VCR_OSEL_OSC_SRC_HI 5
`define VCR_OSEL_OSC_SRC_LO 4
`define VCR_OSEL_REF_SEL 2
`define VCR_CC_OUT_ENABLE 7
`define VCR_CC_CAPTURE_SEL 6
`define VCR_CC_INVERT 5
`define VCR_CC_FORCE_OFF 4
`define VCR_CC_CLAMP_POL 3
`define VCR_CC_CLAMP_SEL 2
`define VCR_CC_VIDEO_AMP_DISABLE 1
`define VCR_CC_FINE_ADJUST_DISABLE 0
`define VCR_RC_INVERT 7
`define VCR_RC_CAL_ACCESS 3
`define VCR_C1_DATA_DELAY 6

`endif

// ===== rtl/vcr_pkg.sv
// Purpose: types for the video converter register bank
// Assumes: constants come from vcr_defines.svh
// Notes: the whole module state is one packed struct
package vcr_pkg;
    typedef logic [7:0] vcr_byte_t;

    // all state of the register bank
    typedef struct packed {
        vcr_byte_t output_select;
        vcr_byte_t converter_control;
        vcr_byte_t red_coarse;
        vcr_byte_t green_coarse;
        vcr_byte_t blue_coarse;
        vcr_byte_t red_fine;
        vcr_byte_t green_fine;
        vcr_byte_t blue_fine;
        vcr_byte_t return_clock;
        vcr_byte_t red_comp;
        vcr_byte_t green_comp;
        vcr_byte_t blue_comp;
        vcr_byte_t cal_one;
        vcr_byte_t cal_two;
        vcr_byte_t rdata;
        logic osc_pin;
        logic lock_status;
        logic ref_status;
        logic out_enable;
        logic mclk_reset;
        logic panel_reset;
    } vcr_state_t;
endpackage

// ===== rtl/vcr_regs.sv
// Purpose: output, clamp, gain, delay and calibration register bank
// Assumes: host port presents index and data with one-cycle strobes
// Notes: all outputs are flip-flops; PLL reload is a one-cycle pulse
`timescale 1ns/1ps
`include "vcr_defines.svh"

module vcr_regs (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire vcr_pkg::vcr_byte_t i_index,
    input wire vcr_pkg::vcr_byte_t i_wdata,
    input wire logic [3:0] i_osc_sources,
    input wire logic [3:0] i_lock_status,
    input wire logic [1:0] i_ref_status,
    output vcr_pkg::vcr_byte_t o_rdata,
    output logic o_oscillator_output_pin,
    output logic o_reported_lock_status,
    output logic o_reported_reference_status,
    output logic o_high_drive,
    output logic o_converter_out_enable,
    output logic o_converter_buffers_off,
    output logic o_converter_invert,
    output logic o_capture_select,
    output logic o_clamp_polarity,
    output logic o_clamp_source_external,
    output logic o_video_amp_disable,
    output logic o_fine_adjust_disable,
    output logic [1:0] o_red_coarse_gain,
    output logic [1:0] o_green_coarse_gain,
    output logic [1:0] o_blue_coarse_gain,
    output vcr_pkg::vcr_byte_t o_red_top_reference_voltage,
    output vcr_pkg::vcr_byte_t o_green_top_reference_voltage,
    output vcr_pkg::vcr_byte_t o_blue_top_reference_voltage,
    output logic o_returned_clock_invert,
    output logic [1:0] o_returned_clock_delay,
    output logic o_cal_access,
    output logic o_gp_output_one_select,
    output logic o_gp_output_two_select,
    output logic o_gp_output_three_select,
    output vcr_pkg::vcr_byte_t o_red_comparator_offset,
    output vcr_pkg::vcr_byte_t o_green_comparator_offset,
    output vcr_pkg::vcr_byte_t o_blue_comparator_offset,
    output logic [2:0] o_colour_data_delay,
    output logic [2:0] o_green_clock_delay,
    output logic [2:0] o_red_clock_delay,
    output logic [2:0] o_blue_clock_delay,
    output logic [2:0] o_bandgap_cal,
    output logic o_mclk_pll_reset,
    output logic o_panel_clock_pll_reset
);
    import vcr_pkg::*;

    vcr_state_t state_q;
    vcr_state_t state_d;

    // =========================================================
    // helpers
    // =========================================================
    // masked write merge, reserved bits stay zero
    function automatic vcr_byte_t write_field(input vcr_byte_t data, input vcr_byte_t mask);
        write_field = data & mask;
    endfunction

    // calibration registers answer only while access is opened
    function automatic logic cal_index(input vcr_byte_t idx);
        cal_index = (idx == `VCR_IDX_CAL_ONE) || (idx == `VCR_IDX_CAL_TWO);
    endfunction

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic cal_open;
        logic hit;
        cal_open = 1'b0;
        hit = 1'b0;
        state_d = state_q;
        cal_open = state_q.return_clock[`VCR_RC_CAL_ACCESS];
        hit = i_wr_en && (!cal_index(i_index) || cal_open);
        state_d.mclk_reset = 1'b0;
        state_d.panel_reset = 1'b0;
        // register writes; unmapped indexes are ignored
        if (hit) begin
            if (i_index == `VCR_IDX_OUTPUT_SELECT) begin
                state_d.output_select = write_field(i_wdata, `VCR_MASK_OUTPUT_SELECT);
            end else if (i_index == `VCR_IDX_AUX_PLL_RESET) begin
                // nibbles are independent triggers, nothing is stored
                state_d.mclk_reset = (i_wdata[7:4] == `VCR_MCLK_TRIGGER);
                state_d.panel_reset = (i_wdata[3:0] == `VCR_PANEL_TRIGGER);
            end else if (i_index == `VCR_IDX_CONVERTER_CTRL) begin
                state_d.converter_control = i_wdata;
            end else if (i_index == `VCR_IDX_RED_COARSE) begin
                state_d.red_coarse = i_wdata;
            end else if (i_index == `VCR_IDX_GREEN_COARSE) begin
                state_d.green_coarse = i_wdata;
            end else if (i_index == `VCR_IDX_BLUE_COARSE) begin
                state_d.blue_coarse = i_wdata;
            end else if (i_index == `VCR_IDX_RED_FINE) begin
                state_d.red_fine = i_wdata;
            end else if (i_index == `VCR_IDX_GREEN_FINE) begin
                state_d.green_fine = i_wdata;
            end else if (i_index == `VCR_IDX_BLUE_FINE) begin
                state_d.blue_fine = i_wdata;
            end else if (i_index == `VCR_IDX_RETURN_CLOCK) begin
                state_d.return_clock = write_field(i_wdata, `VCR_MASK_RETURN_CLOCK);
            end else if (i_index == `VCR_IDX_RED_COMP) begin
                state_d.red_comp = i_wdata;
            end else if (i_index == `VCR_IDX_GREEN_COMP) begin
                state_d.green_comp = i_wdata;
            end else if (i_index == `VCR_IDX_BLUE_COMP) begin
                state_d.blue_comp = i_wdata;
            end else if (i_index == `VCR_IDX_CAL_ONE) begin
                state_d.cal_one = write_field(i_wdata, `VCR_MASK_CAL_ONE);
            end else if (i_index == `VCR_IDX_CAL_TWO) begin
                state_d.cal_two = write_field(i_wdata, `VCR_MASK_FULL);
            end
        end
        // read data, registered one cycle after the strobe
        if (i_rd_en) begin
            if (cal_index(i_index) && !cal_open) begin
                state_d.rdata = 8'h00;
            end else if (i_index == `VCR_IDX_OUTPUT_SELECT) begin
                state_d.rdata = state_q.output_select;
            end else if (i_index == `VCR_IDX_AUX_PLL_RESET) begin
                state_d.rdata = 8'h00;
            end else if (i_index == `VCR_IDX_CONVERTER_CTRL) begin
                state_d.rdata = state_q.converter_control;
            end else if (i_index == `VCR_IDX_RED_COARSE) begin
                state_d.rdata = state_q.red_coarse;
            end else if (i_index == `VCR_IDX_GREEN_COARSE) begin
                state_d.rdata = state_q.green_coarse;
            end else if (i_index == `VCR_IDX_BLUE_COARSE) begin
                state_d.rdata = state_q.blue_coarse;
            end else if (i_index == `VCR_IDX_RED_FINE) begin
                state_d.rdata = state_q.red_fine;
            end else if (i_index == `VCR_IDX_GREEN_FINE) begin
                state_d.rdata = state_q.green_fine;
            end else if (i_index == `VCR_IDX_BLUE_FINE) begin
                state_d.rdata = state_q.blue_fine;
            end else if (i_index == `VCR_IDX_RETURN_CLOCK) begin
                state_d.rdata = state_q.return_clock;
            end else if (i_index == `VCR_IDX_RED_COMP) begin
                state_d.rdata = state_q.red_comp;
            end else if (i_index == `VCR_IDX_GREEN_COMP) begin
                state_d.rdata = state_q.green_comp;
            end else if (i_index == `VCR_IDX_BLUE_COMP) begin
                state_d.rdata = state_q.blue_comp;
            end else if (i_index == `VCR_IDX_CAL_ONE) begin
                state_d.rdata = state_q.cal_one;
            end else if (i_index == `VCR_IDX_CAL_TWO) begin
                state_d.rdata = state_q.cal_two;
            end else begin
                state_d.rdata = 8'h00;
            end
        end
        // muxed pins follow the stored selects, one cycle behind
        state_d.osc_pin = state_q.output_select[`VCR_OSEL_OSC_ENABLE] &&
            i_osc_sources[state_q.output_select[`VCR_OSEL_OSC_SRC_HI:`VCR_OSEL_OSC_SRC_LO]];
        state_d.lock_status = i_lock_status[state_q.output_select[1:0]];
        state_d.ref_status = i_ref_status[state_q.output_select[`VCR_OSEL_REF_SEL]];
        // force off beats the enable, but the enable only drops one cycle after force off is stored
        state_d.out_enable = state_q.converter_control[`VCR_CC_OUT_ENABLE] &&
            !state_q.converter_control[`VCR_CC_FORCE_OFF];
        if (i_reset) begin
            state_d = '0;
            state_d.output_select = `VCR_RST_OUTPUT_SELECT;
            state_d.converter_control = `VCR_RST_CONVERTER_CTRL;
            state_d.red_coarse = `VCR_RST_COARSE;
            state_d.green_coarse = `VCR_RST_COARSE;
            state_d.blue_coarse = `VCR_RST_COARSE;
            state_d.red_fine = `VCR_RST_FINE;
            state_d.green_fine = `VCR_RST_FINE;
            state_d.blue_fine = `VCR_RST_FINE;
            state_d.return_clock = `VCR_RST_RETURN_CLOCK;
            state_d.red_comp = `VCR_RST_COMP;
            state_d.green_comp = `VCR_RST_COMP;
            state_d.blue_comp = `VCR_RST_COMP;
            state_d.cal_one = `VCR_RST_CAL_ONE;
            state_d.cal_two = `VCR_RST_CAL_TWO;
        end
    end

    // =========================================================
    // state register
    // =========================================================
    always_ff @(posedge i_clock) begin
        state_q <= state_d;
    end

    // =========================================================
    // outputs, all slices of the state flops
    // =========================================================
    assign o_rdata = state_q.rdata;
    assign o_oscillator_output_pin = state_q.osc_pin;
    assign o_reported_lock_status = state_q.lock_status;
    assign o_reported_reference_status = state_q.ref_status;
    assign o_high_drive = state_q.output_select[`VCR_OSEL_HIGH_DRIVE];
    assign o_converter_out_enable = state_q.out_enable;
    assign o_converter_buffers_off = state_q.converter_control[`VCR_CC_FORCE_OFF];
    assign o_converter_invert = state_q.converter_control[`VCR_CC_INVERT];
    assign o_capture_select = state_q.converter_control[`VCR_CC_CAPTURE_SEL];
    assign o_clamp_polarity = state_q.converter_control[`VCR_CC_CLAMP_POL];
    assign o_clamp_source_external = state_q.converter_control[`VCR_CC_CLAMP_SEL];
    assign o_video_amp_disable = state_q.converter_control[`VCR_CC_VIDEO_AMP_DISABLE];
    assign o_fine_adjust_disable = state_q.converter_control[`VCR_CC_FINE_ADJUST_DISABLE];
    // coarse gain, reserved upper bits kept but unused
    assign o_red_coarse_gain = state_q.red_coarse[1:0];
    assign o_green_coarse_gain = state_q.green_coarse[1:0];
    assign o_blue_coarse_gain = state_q.blue_coarse[1:0];
    assign o_red_top_reference_voltage = state_q.red_fine;
    assign o_green_top_reference_voltage = state_q.green_fine;
    assign o_blue_top_reference_voltage = state_q.blue_fine;
    // returned clock and general-purpose selects
    assign o_returned_clock_invert = state_q.return_clock[`VCR_RC_INVERT];
    assign o_returned_clock_delay = state_q.return_clock[6:5];
    assign o_cal_access = state_q.return_clock[`VCR_RC_CAL_ACCESS];
    assign o_gp_output_one_select = state_q.return_clock[0];
    assign o_gp_output_two_select = state_q.return_clock[1];
    assign o_gp_output_three_select = state_q.return_clock[2];
    assign o_red_comparator_offset = state_q.red_comp;
    assign o_green_comparator_offset = state_q.green_comp;
    assign o_blue_comparator_offset = state_q.blue_comp;
    // delay field split over two registers, msbs in the second
    assign o_colour_data_delay = {state_q.cal_two[4:3],
        state_q.cal_one[`VCR_C1_DATA_DELAY]};
    assign o_green_clock_delay = state_q.cal_one[5:3];
    assign o_red_clock_delay = state_q.cal_one[2:0];
    assign o_blue_clock_delay = state_q.cal_two[2:0];
    assign o_bandgap_cal = state_q.cal_two[7:5];
    assign o_mclk_pll_reset = state_q.mclk_reset;
    assign o_panel_clock_pll_reset = state_q.panel_reset;
endmodule

// ===== verification/tb_video_adc_output_cal_regs.sv
// Purpose: directed bench for the converter register bank
// Assumes: inputs change on the falling edge only
// Notes: host port traffic goes through the host model
`timescale 1ns/1ps
module tb_video_adc_output_cal_regs;
    import vcr_pkg::*;
    logic i_clock, i_reset, i_wr_en, i_rd_en;
    vcr_byte_t i_index, i_wdata, o_rdata;
    logic [3:0] i_osc_sources, i_lock_status;
    logic [1:0] i_ref_status;
    logic o_oscillator_output_pin, o_reported_lock_status, o_reported_reference_status;
    logic o_high_drive, o_converter_out_enable, o_converter_buffers_off, o_converter_invert;
    logic o_capture_select, o_clamp_polarity, o_clamp_source_external, o_video_amp_disable;
    logic o_fine_adjust_disable, o_returned_clock_invert, o_cal_access, o_gp_output_one_select;
    logic o_gp_output_two_select, o_gp_output_three_select;
    logic o_mclk_pll_reset, o_panel_clock_pll_reset;
    logic [1:0] o_red_coarse_gain, o_green_coarse_gain, o_blue_coarse_gain;
    logic [1:0] o_returned_clock_delay;
    vcr_byte_t o_red_top_reference_voltage, o_green_top_reference_voltage;
    vcr_byte_t o_blue_top_reference_voltage, o_red_comparator_offset;
    vcr_byte_t o_green_comparator_offset, o_blue_comparator_offset;
    logic [2:0] o_colour_data_delay, o_green_clock_delay, o_red_clock_delay;
    logic [2:0] o_blue_clock_delay, o_bandgap_cal;
    int err_count = 0;
    int checked = 0;
    // ==========================================
    // clock, design and host
    initial i_clock = 1'b0;
    always #5 i_clock = ~i_clock;
    vcr_regs u_dut (.*);
    vcr_host_model u_host (.i_clock(i_clock), .i_rdata(o_rdata), .o_wr_en(i_wr_en),
        .o_rd_en(i_rd_en), .o_index(i_index), .o_wdata(i_wdata));
    // ==========================================
    // shared checks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input vcr_byte_t idx, input vcr_byte_t exp);
        vcr_byte_t d;
        u_host.rd(idx, d);
        chk(d, exp);
    endtask
    // power-up contents; gaps and locked calibration read zero
    function automatic vcr_byte_t rst_val(input vcr_byte_t idx);
        case (idx)
            8'h2c: return 8'h41;
            8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36: return 8'h20;
            8'h37: return 8'hc0;
            8'h38, 8'h39, 8'h3a: return 8'h77;
            default: return 8'h00;
        endcase
    endfunction
    // ==========================================
    // scenarios
    task automatic t_reset;
        for (int i = 8'h2c; i <= 8'h3c; i++) begin
            rchk(8'(i), rst_val(8'(i)));
        end
        u_host.wr(8'h37, 8'hc8);
        rchk(8'h3b, 8'h2d);
        rchk(8'h3c, 8'ha5);
        $display("test reset done");
    endtask
    task automatic t_pll;
        vcr_byte_t v [6] = '{8'h5a, 8'h5f, 8'h0a, 8'h55, 8'ha5, 8'h00};
        foreach (v[k]) begin
            u_host.wr(8'h2d, v[k]);
            chk(8'({o_mclk_pll_reset, o_panel_clock_pll_reset}),
                8'({v[k][7:4] == 4'h5, v[k][3:0] == 4'ha}));
            @(negedge i_clock);
            chk(8'({o_mclk_pll_reset, o_panel_clock_pll_reset}), 8'h00);
        end
        rchk(8'h2d, 8'h00);
        $display("test pll trigger done");
    endtask
    task automatic t_osc;
        for (int s = 0; s < 4; s++) begin
            // s*17 puts the select in both the oscillator and lock fields
            u_host.wr(8'h2c, 8'hc0 | 8'(s * 17) | 8'((s & 1) << 2));
            for (int p = 0; p < 2; p++) begin
                i_osc_sources = p ? 4'(1 << s) : ~4'(1 << s);
                i_lock_status = p ? 4'(1 << s) : ~4'(1 << s);
                i_ref_status = p ? 2'(1 << (s & 1)) : ~2'(1 << (s & 1));
                repeat (2) @(negedge i_clock);
                chk(8'({o_oscillator_output_pin, o_reported_lock_status}), 8'(p * 3));
                chk(8'({o_reported_reference_status, o_high_drive}), 8'(p * 2 + 1));
            end
        end
        u_host.wr(8'h2c, 8'h30);
        i_osc_sources = 4'hf;
        repeat (2) @(negedge i_clock);
        chk(8'({o_oscillator_output_pin, o_high_drive}), 8'h00);
        $display("test output select done");
    endtask
    task automatic t_ctrl;
        u_host.wr(8'h30, 8'h80);
        @(negedge i_clock);
        chk(8'({o_converter_out_enable, o_converter_buffers_off, o_converter_invert,
            o_clamp_polarity, o_clamp_source_external}), 8'h10);
        u_host.wr(8'h30, 8'hbc);
        @(negedge i_clock);
        chk(8'({o_converter_out_enable, o_converter_buffers_off, o_converter_invert,
            o_clamp_polarity, o_clamp_source_external}), 8'h0f);
        rchk(8'h30, 8'hbc);
        // capture select and the two disables are plain stored bits
        u_host.wr(8'h30, 8'h43);
        chk(8'({o_capture_select, o_video_amp_disable, o_fine_adjust_disable}), 8'h07);
        $display("test converter control done");
    endtask
    task automatic t_fields;
        u_host.wr(8'h31, 8'h03);
        u_host.wr(8'h35, 8'ha5);
        u_host.wr(8'h39, 8'h3c);
        u_host.wr(8'h37, 8'h5f);
        chk(8'(o_red_coarse_gain), 8'h03);
        chk(o_green_top_reference_voltage, 8'ha5);
        chk(o_green_comparator_offset, 8'h3c);
        chk(8'({o_returned_clock_invert, o_returned_clock_delay, o_cal_access,
            o_gp_output_three_select, o_gp_output_two_select,
            o_gp_output_one_select}), 8'h2f);
        rchk(8'h37, 8'h4f);
        u_host.wr(8'h3b, 8'hff);
        rchk(8'h3b, 8'h7f);
        u_host.wr(8'h3c, 8'h18);
        chk(8'({o_colour_data_delay, o_blue_clock_delay}), 8'h38);
        u_host.wr(8'h3c, 8'he0);
        chk(8'({o_colour_data_delay, o_bandgap_cal}), 8'h0f);
        u_host.wr(8'h37, 8'hc0);
        u_host.wr(8'h3b, 8'h00);
        chk(8'({o_green_clock_delay, o_red_clock_delay}), 8'h3f);
        rchk(8'h3b, 8'h00);
        // remaining channels, so every gain, reference and offset output is seen
        u_host.wr(8'h32, 8'h01);
        u_host.wr(8'h33, 8'h02);
        u_host.wr(8'h34, 8'h5a);
        u_host.wr(8'h36, 8'hc3);
        u_host.wr(8'h38, 8'h12);
        u_host.wr(8'h3a, 8'h9e);
        chk(8'({o_green_coarse_gain, o_blue_coarse_gain}), 8'h06);
        chk(o_red_top_reference_voltage, 8'h5a);
        chk(o_blue_top_reference_voltage, 8'hc3);
        chk(o_red_comparator_offset, 8'h12);
        chk(o_blue_comparator_offset, 8'h9e);
        rchk(8'h33, 8'h02);
        $display("test field map done");
    endtask
    // ==========================================
    // verdict, shared with the watchdog
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // the tests need well under 1000 cycles
    initial begin
        #50000;
        err_count++;
        report_and_stop;
    end
    initial begin
        i_reset = 1'b1;
        i_osc_sources = 4'h0;
        i_lock_status = 4'h0;
        i_ref_status = 2'h0;
        repeat (8) @(negedge i_clock);
        i_reset = 1'b0;
        t_reset;
        t_pll;
        t_osc;
        t_ctrl;
        t_fields;
        // second reset in mid-run must bring every register back to its default
        i_reset = 1'b1;
        repeat (2) @(negedge i_clock);
        i_reset = 1'b0;
        t_reset;
        report_and_stop;
    end
endmodule

// ===== verification/vcr_host_model.sv
// Purpose: host side of the register port, single writes and reads
// Assumes: strobes taken on the rising edge, read data one cycle later
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module vcr_host_model (
    input wire logic i_clock,
    input wire vcr_pkg::vcr_byte_t i_rdata,
    output logic o_wr_en,
    output logic o_rd_en,
    output vcr_pkg::vcr_byte_t o_index,
    output vcr_pkg::vcr_byte_t o_wdata
);
    import vcr_pkg::*;
    // ==========================================
    // idle port at time zero
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_index = 8'h00;
        o_wdata = 8'h00;
    end
    // request held across one rising edge, then released
    task automatic wr(input vcr_byte_t idx, input vcr_byte_t dat);
        @(negedge i_clock);
        o_wr_en = 1'b1;
        o_index = idx;
        o_wdata = dat;
        @(negedge i_clock);
        o_wr_en = 1'b0;
        o_index = ~idx;
        o_wdata = ~dat;
    endtask
    // read data is taken once the strobe edge has passed
    task automatic rd(input vcr_byte_t idx, output vcr_byte_t dat);
        @(negedge i_clock);
        o_rd_en = 1'b1;
        o_index = idx;
        @(negedge i_clock);
        o_rd_en = 1'b0;
        o_index = ~idx;
        dat = i_rdata;
    endtask
endmodule

// ===== verification/vcr_regs_chk.sv
// Purpose: port-level checks on the converter register bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound to vcr_regs at the foot of this file
`timescale 1ns/1ps
module vcr_regs_chk (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_wr_en,
    input wire vcr_pkg::vcr_byte_t i_index,
    input wire vcr_pkg::vcr_byte_t i_wdata,
    input wire logic o_oscillator_output_pin,
    input wire logic o_converter_out_enable,
    input wire logic o_converter_buffers_off,
    input wire logic [1:0] o_red_coarse_gain,
    input wire vcr_pkg::vcr_byte_t o_green_top_reference_voltage,
    input wire logic o_returned_clock_invert,
    input wire logic [1:0] o_returned_clock_delay,
    input wire logic o_cal_access,
    input wire vcr_pkg::vcr_byte_t o_blue_comparator_offset,
    input wire logic [2:0] o_colour_data_delay,
    input wire logic [2:0] o_red_clock_delay,
    input wire logic [2:0] o_blue_clock_delay,
    input wire logic o_mclk_pll_reset,
    input wire logic o_panel_clock_pll_reset
);
    import vcr_pkg::*;
    vcr_byte_t wr_idx;
    vcr_byte_t wd_q;
    // ==========================================
    // helpers
    // idle index reads as zero so no index match fires without a write
    assign wr_idx = i_wr_en ? i_index : 8'h00;
    // last cycle's write data, avoids $past on part-selects
    always_ff @(posedge i_clock) begin
        wd_q <= i_wdata;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // ==========================================
    // properties
    chk_mclk_pulse: assert property (
        wr_idx == 8'h2d && i_wdata[7:4] == 4'h5 |=> o_mclk_pll_reset)
        else $error("memory pll reset pulse missing");
    chk_panel_pulse: assert property (
        wr_idx == 8'h2d && i_wdata[3:0] == 4'ha |=> o_panel_clock_pll_reset)
        else $error("panel pll reset pulse missing");
    chk_no_trigger: assert property (
        !(wr_idx == 8'h2d && i_wdata[7:4] == 4'h5) |=> !o_mclk_pll_reset)
        else $error("memory pll reset without trigger");
    chk_no_panel: assert property (
        !(wr_idx == 8'h2d && i_wdata[3:0] == 4'ha) |=> !o_panel_clock_pll_reset)
        else $error("panel pll reset without trigger");
    chk_osc_gate: assert property (
        (wr_idx == 8'h2c && !i_wdata[6]) ##1 wr_idx != 8'h2c
        |=> !o_oscillator_output_pin) else $error("oscillator pin driven while disabled");
    chk_force_off: assert property (
        o_converter_buffers_off [*2] |-> !o_converter_out_enable)
        else $error("outputs enabled while forced off");
    chk_coarse_gain: assert property (
        wr_idx == 8'h31 |=> o_red_coarse_gain == wd_q[1:0])
        else $error("coarse gain not taken");
    chk_fine_ref: assert property (
        wr_idx == 8'h35 |=> o_green_top_reference_voltage == wd_q)
        else $error("fine reference not taken");
    chk_ret_clock: assert property (
        wr_idx == 8'h37 |=> o_returned_clock_invert == wd_q[7]
        && o_returned_clock_delay == wd_q[6:5] && o_cal_access == wd_q[3])
        else $error("returned clock fields not taken");
    chk_comp_offset: assert property (
        wr_idx == 8'h3a |=> o_blue_comparator_offset == wd_q)
        else $error("comparator offset not taken");
    chk_cal_locked: assert property (
        wr_idx == 8'h3b && !o_cal_access |=> $stable(o_red_clock_delay))
        else $error("calibration written while locked");
    chk_cal_two: assert property (
        wr_idx == 8'h3c && o_cal_access
        |=> {o_colour_data_delay[2:1], o_blue_clock_delay} == wd_q[4:0])
        else $error("second calibration fields not taken");
endmodule

bind vcr_regs vcr_regs_chk u_chk (.*);
